// File: rtl/lsi_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "lsi_regs.svh"
module lsi_top #(
    parameter int INPUT_UNDER_THRESHOLD_CYCLES = `LSI_INPUT_UNDER_THRESHOLD_TIME_US * (`LSI_CLK_KHZ / 1000),
    parameter int TMR_T1_LONG = `LSI_T1_RATE_KHZ * (`LSI_TMR_LONG_US / 1000),
    parameter int TMR_T1_SHORT = `LSI_T1_RATE_KHZ * `LSI_TMR_T1_SHORT_US / 1000,
    parameter int TMR_E1_LONG = `LSI_E1_RATE_KHZ * (`LSI_TMR_LONG_US / 1000),
    parameter int TMR_E1_SHORT = `LSI_E1_RATE_KHZ * `LSI_TMR_E1_SHORT_US / 1000,
    parameter int CH = 8,
    parameter logic [3:0] RL_MAX_E1_EGL = 4'hF
) (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire lsi_pkg::lsi_host_req_type host_req_in,
    output logic [7:0] host_rdata_out,
    output logic irq_out,
    input wire logic mclk_tick_in,
    input wire logic pll_tick_in,
    output logic jitter_atten_clock_out,
    input wire logic tx_data_in,
    input wire logic tx_cmi_in,
    output logic tx_line_pos_out,
    input wire logic rx_line_pos_in,
    output logic rx_data_out,
    output logic cmi_mode_out,
    input wire lsi_pkg::lsi_line_cond_type line_cond_in,
    input wire logic eq_gain_limit_in,
    input wire logic li_tx_clock_in,
    input wire logic bert_bit_tick_in,
    input wire logic bert_bit_err_in,
    input wire logic rx_bit_tick_in,
    input wire logic err_count_interval_sel_in,
    input wire logic [CH-1:0] sig_change_in,
    input wire logic [CH-1:0] sig_change_enable_1_in
);
    import lsi_pkg::*;

    localparam int TMR_W = 22;
    localparam int INPUT_UNDER_THRESHOLD_W = 24;

    // ********************
    // host registers
    // ********************
    logic [7:0] imr_r; // interrupt mask
    logic [7:0] lic2_r; // mode and jitter clock source
    logic [7:0] lic4_r; // cmi and prescaler
    logic [7:0] sr1_r; // latched status
    logic [7:0] pend_r; // interrupt pending
    logic [7:0] cond_q_r; // previous conditions

    wire sel_info_w = host_req_in.addr == `LSI_ADDR_INFO_RT;
    wire sel_sr1_w = host_req_in.addr == `LSI_ADDR_STATUS_EV;
    wire sel_imr_w = host_req_in.addr == `LSI_ADDR_IRQ_MASK;
    wire sel_lic2_w = host_req_in.addr == `LSI_ADDR_LI_CTRL2;
    wire sel_lic4_w = host_req_in.addr == `LSI_ADDR_LI_CTRL4;
    wire rd_sr1_w = host_req_in.rd && sel_sr1_w;

    wire e1_w = lic2_r[`LSI_LIC2_E1_BIT];
    wire jsrc_pll_w = lic2_r[`LSI_LIC2_JSRC_BIT];
    wire cmi_coding_enable_w = lic4_r[`LSI_LIC4_CMI_CODING_ENABLE_BIT];
    wire cmi_polarity_invert_w = lic4_r[`LSI_LIC4_CMI_POLARITY_INVERT_BIT];
    wire [1:0] mps_w = lic4_r[`LSI_LIC4_MPS_HI:`LSI_LIC4_MPS_LO];

    // control register writes
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            imr_r <= `LSI_RST_BYTE;
            lic2_r <= `LSI_RST_BYTE;
            lic4_r <= `LSI_RST_BYTE;
        end else if (host_req_in.wr) begin
            if (sel_imr_w) begin
                imr_r <= host_req_in.wdata;
            end else if (sel_lic2_w) begin
                lic2_r <= host_req_in.wdata;
            end else if (sel_lic4_w) begin
                lic4_r <= host_req_in.wdata;
            end
        end
    end

    // ********************
    // prescaler and jitter clock
    // ********************
    logic [2:0] pre_cnt_r; // master clock ticks
    wire [2:0] pre_mask_w = 3'((4'h1 << mps_w) - 4'h1); // divide by 1,2,4,8
    wire base_tick_w = mclk_tick_in && ((pre_cnt_r & pre_mask_w) == pre_mask_w);
    wire jclk_nxt = jsrc_pll_w ? pll_tick_in : base_tick_w;

    // divider and jitter clock enable
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            pre_cnt_r <= 3'h0;
            jitter_atten_clock_out <= 1'b0;
        end else begin
            if (mclk_tick_in) begin
                pre_cnt_r <= base_tick_w ? 3'h0 : pre_cnt_r + 3'h1;
            end
            jitter_atten_clock_out <= jclk_nxt;
        end
    end

    // ********************
    // cmi line coding
    // ********************
    wire tx_pos_nxt = cmi_coding_enable_w ? (tx_cmi_in ^ cmi_polarity_invert_w) : tx_data_in;
    wire rx_data_nxt = rx_line_pos_in ^ (cmi_coding_enable_w & cmi_polarity_invert_w);

    // line pins
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            tx_line_pos_out <= 1'b0;
            rx_data_out <= 1'b0;
            cmi_mode_out <= 1'b0;
        end else begin
            tx_line_pos_out <= tx_pos_nxt;
            rx_data_out <= rx_data_nxt;
            cmi_mode_out <= cmi_coding_enable_w;
        end
    end

    // ********************
    // real-time status
    // ********************
    logic [3:0] rl_r; // receive level band
    logic tx_open_circuit_r; // open circuit
    logic tx_current_limit_hit_r; // current limit
    logic bd_r; // bitcode detected
    logic rx_carrier_lost_r; // carrier lost
    logic jfl_q_r; // previous fifo limit
    logic bert_sync_live; // from synchroniser
    wire [3:0] rl_max_w = e1_w ? RL_MAX_E1_EGL : `LSI_RL_MAX_T1_EGL;
    wire rl_clamp_w = eq_gain_limit_in && (line_cond_in.rx_level > rl_max_w);
    wire [3:0] rl_nxt = rl_clamp_w ? rl_max_w : line_cond_in.rx_level;

    // sample front-end conditions
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rl_r <= 4'h0;
            tx_open_circuit_r <= 1'b0;
            tx_current_limit_hit_r <= 1'b0;
            bd_r <= 1'b0;
            rx_carrier_lost_r <= 1'b0;
            jfl_q_r <= 1'b0;
        end else begin
            rl_r <= rl_nxt;
            tx_open_circuit_r <= line_cond_in.tx_open_circuit;
            tx_current_limit_hit_r <= line_cond_in.tx_current_limit_hit;
            bd_r <= line_cond_in.bitcode_detected;
            rx_carrier_lost_r <= line_cond_in.rx_carrier_lost;
            jfl_q_r <= line_cond_in.jitter_fifo_limit;
        end
    end

    lsi_bert_sync u_bert (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .bit_tick_in(bert_bit_tick_in),
        .bit_err_in(bert_bit_err_in),
        .sync_out(bert_sync_live)
    );

    // ********************
    // transmit clock loss and under-threshold timers
    // ********************
    logic txc_q_r; // previous transmit clock level
    logic [3:0] txc_cnt_r; // base ticks since last toggle
    logic tx_clock_lost; // condition
    logic [INPUT_UNDER_THRESHOLD_W-1:0] input_under_threshold_cnt_r; // cycles below threshold
    logic input_under_threshold_r; // condition
    wire txc_toggle_w = li_tx_clock_in ^ txc_q_r;
    wire txc_full_w = txc_cnt_r == 4'(`LSI_CHAN_BITS);
    wire input_under_threshold_full_w = input_under_threshold_cnt_r == INPUT_UNDER_THRESHOLD_W'(INPUT_UNDER_THRESHOLD_CYCLES - 1);

    // watchdogs
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            txc_q_r <= 1'b0;
            txc_cnt_r <= 4'h0;
            tx_clock_lost <= 1'b0;
            input_under_threshold_cnt_r <= '0;
            input_under_threshold_r <= 1'b0;
        end else begin
            txc_q_r <= li_tx_clock_in;
            if (txc_toggle_w) begin
                txc_cnt_r <= 4'h0;
                tx_clock_lost <= 1'b0;
            end else if (base_tick_w && !txc_full_w) begin
                txc_cnt_r <= txc_cnt_r + 4'h1;
            end else if (txc_full_w) begin
                tx_clock_lost <= 1'b1;
            end
            if (!line_cond_in.level_below_thresh) begin
                input_under_threshold_cnt_r <= '0;
                input_under_threshold_r <= 1'b0;
            end else if (input_under_threshold_full_w) begin
                input_under_threshold_r <= 1'b1;
            end else begin
                input_under_threshold_cnt_r <= input_under_threshold_cnt_r + INPUT_UNDER_THRESHOLD_W'(1);
            end
        end
    end

    // ********************
    // error-counter interval timer
    // ********************
    logic [TMR_W-1:0] tmr_cnt_r; // receive bit ticks
    wire [TMR_W-1:0] tmr_last_w = e1_w
        ? (err_count_interval_sel_in ? TMR_W'(TMR_E1_SHORT - 1) : TMR_W'(TMR_E1_LONG - 1))
        : (err_count_interval_sel_in ? TMR_W'(TMR_T1_SHORT - 1) : TMR_W'(TMR_T1_LONG - 1));
    wire tmr_ev_w = rx_bit_tick_in && (tmr_cnt_r >= tmr_last_w);

    // interval count on receive clock
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            tmr_cnt_r <= '0;
        end else if (rx_bit_tick_in) begin
            tmr_cnt_r <= tmr_ev_w ? '0 : tmr_cnt_r + TMR_W'(1);
        end
    end

    // ********************
    // latched status and interrupt
    // ********************
    wire sig_ev_w = |(sig_change_in & sig_change_enable_1_in);
    wire jitter_fifo_limit_ev_w = line_cond_in.jitter_fifo_limit && !jfl_q_r;
    wire [7:0] cond_w = {input_under_threshold_r, 3'h0, rx_carrier_lost_r, tx_current_limit_hit_r, tx_open_circuit_r, tx_clock_lost};
    wire [7:0] ev_w = {1'b0, tmr_ev_w, sig_ev_w, jitter_fifo_limit_ev_w, 4'h0};
    wire [7:0] edge_w = (cond_w ^ cond_q_r) & `LSI_SR1_COND_MASK;
    wire [7:0] set_w = edge_w | ev_w;
    // set wins over read clear; present conditions stay latched in sr1_r, not in pend_r
    wire [7:0] sr1_nxt = rd_sr1_w ? (set_w | (cond_w & `LSI_SR1_COND_MASK)) : (sr1_r | set_w);
    wire [7:0] pend_nxt = rd_sr1_w ? set_w : (pend_r | set_w);

    // status latches
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            sr1_r <= `LSI_RST_BYTE;
            pend_r <= `LSI_RST_BYTE;
            cond_q_r <= `LSI_RST_BYTE;
            irq_out <= 1'b0;
        end else begin
            sr1_r <= sr1_nxt;
            pend_r <= pend_nxt;
            cond_q_r <= cond_w;
            irq_out <= |(pend_r & imr_r);
        end
    end

    // ********************
    // read data
    // ********************
    logic [7:0] rdata_nxt; // decoded read value
    always_comb begin
        rdata_nxt = 8'h00;
        if (sel_info_w) begin
            rdata_nxt = {bert_sync_live, bd_r, tx_current_limit_hit_r, tx_open_circuit_r, rl_r};
        end else if (sel_sr1_w) begin
            rdata_nxt = sr1_r;
        end else if (sel_imr_w) begin
            rdata_nxt = imr_r;
        end else if (sel_lic2_w) begin
            rdata_nxt = lic2_r;
        end else if (sel_lic4_w) begin
            rdata_nxt = lic4_r;
        end
    end

    // read data flop, holds until next read
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            host_rdata_out <= 8'h00;
        end else if (host_req_in.rd) begin
            host_rdata_out <= rdata_nxt;
        end
    end

    // ********************
    // checks
    // ********************
    a_irq_mask_gate: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (|(pend_r & imr_r)) |=> irq_out)
        else $error("masked pending bit did not raise irq");
    a_irq_blocked: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        (imr_r == 8'h00) ##1 (imr_r == 8'h00) |-> !irq_out)
        else $error("irq with all sources masked");
    a_cond_edge_latch: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        $changed(rx_carrier_lost_r) |=> sr1_r[3] && pend_r[3])
        else $error("carrier loss edge not latched");
    a_event_read_clear: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        rd_sr1_w && !jitter_fifo_limit_ev_w |=> !sr1_r[4])
        else $error("fifo limit event not cleared by read");
    a_event_set_wins: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        rd_sr1_w && tmr_ev_w |=> sr1_r[6] && pend_r[6])
        else $error("timer event lost in clearing read");
    a_cmi_tx_invert: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        cmi_coding_enable_w && cmi_polarity_invert_w |=> tx_line_pos_out == !$past(tx_cmi_in))
        else $error("cmi transmit not inverted");
    a_rl_clamp_t1: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        eq_gain_limit_in && !e1_w |=> rl_r <= `LSI_RL_MAX_T1_EGL)
        else $error("receive level beyond gain limit");
    a_txclk_lost_time: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        $rose(tx_clock_lost) |-> $past(txc_cnt_r) == 4'(`LSI_CHAN_BITS))
        else $error("transmit clock loss too early");
    a_input_under_threshold_hold_time: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        $rose(input_under_threshold_r) |-> $past(input_under_threshold_cnt_r) == INPUT_UNDER_THRESHOLD_W'(INPUT_UNDER_THRESHOLD_CYCLES - 1))
        else $error("under threshold flagged early");
    a_jclk_source: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        jsrc_pll_w |=> jitter_atten_clock_out == $past(pll_tick_in))
        else $error("jitter clock not from pll");
endmodule
`default_nettype wire

// File: rtl/lsi_regs.svh
// Function
// - T1 prescaler codes select master clock rate
// - E1 prescaler codes select 2.048 to 16.384
// - invert bit flips coded-mark-inversion on pins
// - enable bit switches line into coded-mark-inversion
// - four-bit receive level in 2.5 dB bands
// - receive level clamped to 5 by equalizer gain limit in T1; E1 limit 4'hF never clamps
// - real-time current-limiter active status bit
// - real-time bit-oriented-code detected status bit
// - bert sync after 32 matches, lost 6/64
// - transmit clock lost after one channel time
// - carrier, open, current-limit flags interrupt both edges
// - jitter fifo limit event, clears on read
// - enabled channel signaling change sets event
// - timer event at error-counter update interval
// - under-threshold flag after 50ms below threshold
// - mask bit 0 blocks, 1 enables source
// - jitter clock from master clock or pll
`ifndef LSI_REGS_SVH
`define LSI_REGS_SVH

// ********************
// register offsets
// ********************
`define LSI_ADDR_INFO_RT 8'h11
`define LSI_ADDR_STATUS_EV 8'h16
`define LSI_ADDR_IRQ_MASK 8'h17
`define LSI_ADDR_LI_CTRL2 8'h79
`define LSI_ADDR_LI_CTRL4 8'h7B

// ********************
// reset values and fields
// ********************
`define LSI_RST_BYTE 8'h00
`define LSI_LIC2_E1_BIT 7
`define LSI_LIC2_JSRC_BIT 3
`define LSI_LIC4_CMI_CODING_ENABLE_BIT 7
`define LSI_LIC4_CMI_POLARITY_INVERT_BIT 6
`define LSI_LIC4_MPS_HI 5
`define LSI_LIC4_MPS_LO 4
`define LSI_SR1_COND_MASK 8'h8F
`define LSI_RL_MAX_T1_EGL 4'h5

// ********************
// timing
// ********************
`define LSI_CLK_KHZ 25000
`define LSI_INPUT_UNDER_THRESHOLD_TIME_US 50000
`define LSI_CHAN_BITS 8
`define LSI_BERT_LOCK_BITS 32
`define LSI_BERT_WIN_BITS 64
`define LSI_BERT_ERR_LIMIT 6
`define LSI_T1_RATE_KHZ 1544
`define LSI_E1_RATE_KHZ 2048
`define LSI_TMR_LONG_US 1000000
`define LSI_TMR_T1_SHORT_US 42000
`define LSI_TMR_E1_SHORT_US 62500

`endif

// File: rtl/lsi_pkg.sv
package lsi_pkg;
    // host parallel port request, one cycle strobes
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic rd;
        logic wr;
    } lsi_host_req_type;

    // raw line interface conditions from analog front end
    typedef struct packed {
        logic [3:0] rx_level;
        logic tx_open_circuit;
        logic tx_current_limit_hit;
        logic bitcode_detected;
        logic rx_carrier_lost;
        logic level_below_thresh;
        logic jitter_fifo_limit;
    } lsi_line_cond_type;

    // bert synchroniser states
    typedef enum logic [0:0] {
        LSI_BERT_HUNT,
        LSI_BERT_LOCKED
    } lsi_bert_state_type;
endpackage

// File: rtl/lsi_bert_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "lsi_regs.svh"
module lsi_bert_sync (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic bit_tick_in,
    input wire logic bit_err_in,
    output logic sync_out
);
    import lsi_pkg::*;

    // ********************
    // state
    // ********************
    lsi_bert_state_type state_r; // hunt or locked
    logic [5:0] match_cnt_r; // consecutive good bits
    logic [5:0] win_cnt_r; // bit position in 64 window
    logic [2:0] err_cnt_r; // errors in window

    wire lock_w = bit_tick_in && !bit_err_in && (match_cnt_r == 6'(`LSI_BERT_LOCK_BITS - 1));
    wire lose_w = bit_tick_in && bit_err_in && (err_cnt_r == 3'(`LSI_BERT_ERR_LIMIT - 1));
    wire win_end_w = bit_tick_in && (win_cnt_r == 6'(`LSI_BERT_WIN_BITS - 1));

    // ********************
    // synchroniser
    // ********************
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_r <= LSI_BERT_HUNT;
            match_cnt_r <= 6'h00;
            win_cnt_r <= 6'h00;
            err_cnt_r <= 3'h0;
        end else if (bit_tick_in) begin
            case (state_r)
                LSI_BERT_HUNT: begin
                    // need 32 matching in a row
                    match_cnt_r <= bit_err_in ? 6'h00 : match_cnt_r + 6'h01;
                    win_cnt_r <= 6'h00;
                    err_cnt_r <= 3'h0;
                    if (lock_w) begin
                        state_r <= LSI_BERT_LOCKED;
                    end
                end
                LSI_BERT_LOCKED: begin
                    // sixth error within 64 bits drops sync
                    match_cnt_r <= 6'h00;
                    win_cnt_r <= win_cnt_r + 6'h01;
                    if (lose_w) begin
                        state_r <= LSI_BERT_HUNT;
                        err_cnt_r <= 3'h0;
                        win_cnt_r <= 6'h00;
                    end else if (win_end_w) begin
                        err_cnt_r <= 3'h0;
                    end else if (bit_err_in) begin
                        err_cnt_r <= err_cnt_r + 3'h1;
                    end
                end
                default: begin
                    state_r <= LSI_BERT_HUNT;
                end
            endcase
        end
    end

    // sync flop from state
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            sync_out <= 1'b0;
        end else begin
            sync_out <= (state_r == LSI_BERT_LOCKED);
        end
    end

    a_bert_lock_count: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        $rose(state_r == LSI_BERT_LOCKED) |-> $past(match_cnt_r) == 6'(`LSI_BERT_LOCK_BITS - 1))
        else $error("bert locked without 32 matches");
    a_bert_lose_count: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        $fell(state_r == LSI_BERT_LOCKED) |-> $past(err_cnt_r) == 3'(`LSI_BERT_ERR_LIMIT - 1))
        else $error("bert lost sync at wrong error count");
endmodule
`default_nettype wire

// File: bench/lsi_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// line side model
// ****************
module lsi_line_model (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic run_in,
    input wire logic tx_line_pos_in,
    output logic li_tx_clock_out,
    output logic mclk_tick_out,
    output logic rx_line_pos_out
);
    // master tick every other cycle, tx clock stands still when not running
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            li_tx_clock_out <= 1'b0;
            mclk_tick_out <= 1'b0;
            rx_line_pos_out <= 1'b0;
        end else begin
            mclk_tick_out <= ~mclk_tick_out;
            if (run_in) begin
                li_tx_clock_out <= ~li_tx_clock_out;
            end
            // line loops transmit back to receive
            rx_line_pos_out <= tx_line_pos_in;
        end
    end
endmodule
`default_nettype wire

// File: bench/lsi_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module lsi_top_test;
    import lsi_pkg::*;
    // ****************
    // stimulus and wiring
    // ****************
    logic clk = 1'b0;
    logic rst = 1'b1;
    lsi_host_req_type rq = '0;
    lsi_line_cond_type lc = '0;
    logic [7:0] rdata;
    logic irq, jclk, txp, rxd, cmim, rxp, ltc, mtk;
    logic cmi = 1'b0, eq = 1'b0, bt = 1'b0, rt = 1'b0, run = 1'b1;
    logic pll = 1'b0, txd = 1'b0, berr = 1'b0, ecs = 1'b0;
    logic [7:0] sc = 8'h00, sce = 8'h00;
    int n_fail = 0;
    int n_tests = 0;
    lsi_top #(.INPUT_UNDER_THRESHOLD_CYCLES(20), .TMR_T1_LONG(16), .TMR_T1_SHORT(8), .TMR_E1_LONG(16),
        .TMR_E1_SHORT(16)) i_lsi_top (.ref_clk_in(clk), .reset_in(rst), .host_req_in(rq),
        .host_rdata_out(rdata), .irq_out(irq), .mclk_tick_in(mtk), .pll_tick_in(pll),
        .jitter_atten_clock_out(jclk), .tx_data_in(txd), .tx_cmi_in(cmi), .tx_line_pos_out(txp),
        .rx_line_pos_in(rxp), .rx_data_out(rxd), .cmi_mode_out(cmim), .line_cond_in(lc),
        .eq_gain_limit_in(eq), .li_tx_clock_in(ltc), .bert_bit_tick_in(bt), .bert_bit_err_in(berr),
        .rx_bit_tick_in(rt), .err_count_interval_sel_in(ecs), .sig_change_in(sc),
        .sig_change_enable_1_in(sce));
    lsi_line_model i_lsi_line_model (.ref_clk_in(clk), .reset_in(rst), .run_in(run),
        .tx_line_pos_in(txp), .li_tx_clock_out(ltc), .mclk_tick_out(mtk), .rx_line_pos_out(rxp));
    // 25 MHz clock
    initial begin
        forever #20 clk = ~clk;
    end
    // ****************
    // shared tasks
    // ****************
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one cycle read strobe, data settled after the taking edge
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        rq.addr <= a;
        rq.rd <= 1'b1;
        @(posedge clk);
        rq.rd <= 1'b0;
        #1 rdata = i_lsi_top.host_rdata_out;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] exp, input string nm);
        rd(a);
        chk(nm, rdata, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        rq.addr <= a;
        rq.wdata <= d;
        rq.wr <= 1'b1;
        @(posedge clk);
        rq.wr <= 1'b0;
    endtask
    task automatic irq_is(input logic exp);
        #1 chk("irq", {7'h00, irq}, {7'h00, exp});
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_regs;
        rc(8'h11, 8'h00, "info reset");
        rc(8'h16, 8'h00, "status reset");
        rc(8'h17, 8'h00, "mask reset");
        wr(8'h17, 8'hA5);
        rc(8'h17, 8'hA5, "mask rw");
        wr(8'h11, 8'hFF);
        rc(8'h11, 8'h00, "info ro");
        rc(8'h3C, 8'h00, "unmapped");
        wr(8'h17, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_cmi;
        wr(8'h7B, 8'hC0);
        cmi <= 1'b1;
        cyc(4);
        chk("cmi tx inv", {7'h00, txp}, 8'h00);
        chk("cmi rx inv", {7'h00, rxd}, 8'h01);
        chk("cmi mode", {7'h00, cmim}, 8'h01);
        wr(8'h7B, 8'h80);
        cyc(3);
        chk("cmi tx norm", {7'h00, txp}, 8'h01);
        cmi <= 1'b0;
        txd <= 1'b1;
        wr(8'h7B, 8'h00);
        cyc(3);
        chk("cmi off tx", {7'h00, txp}, 8'h01);
        chk("cmi off mode", {7'h00, cmim}, 8'h00);
        $display("test cmi done");
    endtask
    // count jitter clock pulses over 32 cycles
    task automatic pulses(input logic [7:0] exp, input string nm);
        logic [7:0] n;
        n = 8'h00;
        repeat (32) begin
            @(posedge clk);
            #1 if (jclk) n++;
        end
        chk(nm, n, exp);
    endtask
    task automatic t_jclk;
        wr(8'h7B, 8'h30);
        cyc(2);
        pulses(8'h02, "prescale 8");
        wr(8'h79, 8'h80);
        wr(8'h7B, 8'h10);
        cyc(2);
        pulses(8'h08, "prescale 2");
        wr(8'h79, 8'h88);
        pll <= 1'b1;
        cyc(3);
        chk("jclk pll hi", {7'h00, jclk}, 8'h01);
        pll <= 1'b0;
        cyc(3);
        chk("jclk pll lo", {7'h00, jclk}, 8'h00);
        wr(8'h79, 8'h00);
        wr(8'h7B, 8'h00);
        $display("test jclk done");
    endtask
    task automatic t_info;
        lc <= '{rx_level: 4'h9, tx_open_circuit: 1'b1, tx_current_limit_hit: 1'b1,
            bitcode_detected: 1'b1, default: 1'b0};
        cyc(4);
        rc(8'h11, 8'h79, "info live");
        eq <= 1'b1;
        cyc(4);
        rc(8'h11, 8'h75, "t1 clamp");
        wr(8'h79, 8'h80);
        cyc(4);
        rc(8'h11, 8'h79, "e1 no clamp");
        wr(8'h79, 8'h00);
        eq <= 1'b0;
        lc <= '0;
        cyc(4);
        rc(8'h16, 8'h06, "cond edges");
        rc(8'h16, 8'h00, "cond reload");
        $display("test info done");
    endtask
    task automatic t_carrier;
        wr(8'h17, 8'h08);
        lc.rx_carrier_lost <= 1'b1;
        cyc(5);
        irq_is(1'b1);
        rc(8'h16, 8'h08, "carrier set");
        cyc(2);
        irq_is(1'b0);
        rc(8'h16, 8'h08, "carrier held");
        lc.rx_carrier_lost <= 1'b0;
        cyc(5);
        irq_is(1'b1);
        rc(8'h16, 8'h08, "carrier fall");
        rc(8'h16, 8'h00, "carrier gone");
        $display("test carrier done");
    endtask
    task automatic t_jitter;
        wr(8'h17, 8'h10);
        lc.jitter_fifo_limit <= 1'b1;
        cyc(5);
        irq_is(1'b1);
        rc(8'h16, 8'h10, "jitter set");
        lc.jitter_fifo_limit <= 1'b0;
        cyc(5);
        irq_is(1'b0);
        rc(8'h16, 8'h00, "jitter rc");
        wr(8'h17, 8'h00);
        lc.jitter_fifo_limit <= 1'b1;
        cyc(5);
        irq_is(1'b0);
        lc.jitter_fifo_limit <= 1'b0;
        rc(8'h16, 8'h10, "jitter masked");
        $display("test jitter done");
    endtask
    task automatic t_sig;
        sce <= 8'h04;
        sc <= 8'h08;
        cyc(1);
        sc <= 8'h00;
        cyc(4);
        rc(8'h16, 8'h00, "sig other ch");
        sc <= 8'h04;
        cyc(1);
        sc <= 8'h00;
        cyc(4);
        rc(8'h16, 8'h20, "sig change");
        $display("test sig done");
    endtask
    // rx ticks, bert ticks held for n cycles; low level is set and left held
    task automatic hold(input int n, input int k);
        if (k == 0) rt <= 1'b1;
        if (k == 1) bt <= 1'b1;
        if (k == 2) lc.level_below_thresh <= 1'b1;
        if (k == 3) begin
            bt <= 1'b1;
            berr <= 1'b1;
        end
        cyc(n);
        rt <= 1'b0;
        bt <= 1'b0;
        berr <= 1'b0;
    endtask
    task automatic t_counts;
        hold(14, 0);
        rc(8'h16, 8'h00, "timer early");
        hold(6, 0);
        rc(8'h16, 8'h40, "timer set");
        ecs <= 1'b1;
        hold(4, 0);
        ecs <= 1'b0;
        rc(8'h16, 8'h40, "timer short");
        hold(20, 1);
        rc(8'h11, 8'h00, "bert early");
        hold(16, 1);
        cyc(3);
        rc(8'h11, 8'h80, "bert sync");
        hold(5, 3);
        cyc(3);
        rc(8'h11, 8'h80, "bert holds");
        hold(1, 3);
        cyc(3);
        rc(8'h11, 8'h00, "bert lost");
        hold(12, 2);
        rc(8'h16, 8'h00, "input_under_threshold early");
        cyc(15);
        rc(8'h16, 8'h80, "input_under_threshold set");
        lc.level_below_thresh <= 1'b0;
        cyc(4);
        rc(8'h16, 8'h80, "input_under_threshold fall");
        rc(8'h16, 8'h00, "input_under_threshold gone");
        $display("test counts done");
    endtask
    task automatic t_txclk;
        run <= 1'b0;
        cyc(40);
        rc(8'h16, 8'h01, "txclk lost");
        run <= 1'b1;
        cyc(6);
        rc(8'h16, 8'h01, "txclk back");
        rc(8'h16, 8'h00, "txclk gone");
        $display("test txclk done");
    endtask
    // ****************
    // verdict
    // ****************
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        cyc(6);
        rst <= 1'b0;
        t_regs();
        t_cmi();
        t_jclk();
        t_info();
        t_carrier();
        t_jitter();
        t_sig();
        t_counts();
        t_txclk();
        wrap_up();
    end
    // watchdog well past the expected run
    initial begin
        #(40 * 3000);
        n_fail++;
        wrap_up();
    end
endmodule
`default_nettype wire
